// file: rtl/tsmp_packer.sv
// Purpose: builds status message packets into the message buffer
// Assumes: status side runs on i_core_clk, no synchronisers needed
// Notes: buffer words are read by the host over apb

`timescale 1ns/1ps
`include "tsmp_defs.svh"

// Functional notes
// - command answers set header acknowledge bit
// - attention messages leave acknowledge clear
// - header bits 14-12 written zero
// - class code unless normal end
// - packet format field always 000
// - message type field 10xxx form
// - length word upper byte zero
// - length 10, or 12 with extended
// - read residual is requested minus transferred
// - space/skip residual requested minus passed
// - extended status words in words three-seven
// - online/offline attention uses class 0000
// - fail class codes 1, 2, 3
// - message type follows termination class
// - ready clear, write, then ready set and notify together
module tsmp_packer (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // command completion
  input wire logic i_cmd_done,
  input wire tsmp_pkg::tsmp_cmd_t i_cmd_kind,
  input wire logic [2:0] i_tclass,
  input wire logic [3:0] i_class_code,
  input wire tsmp_pkg::tsmp_word_t i_req_count,
  input wire tsmp_pkg::tsmp_word_t i_act_count,
  // extended status
  input wire tsmp_pkg::tsmp_word_t i_ext_status_0,
  input wire tsmp_pkg::tsmp_word_t i_ext_status_1,
  input wire tsmp_pkg::tsmp_word_t i_ext_status_2,
  input wire tsmp_pkg::tsmp_word_t i_ext_status_3,
  input wire tsmp_pkg::tsmp_word_t i_ext_status_4,
  // attention conditions
  input wire logic i_attention_message_line,
  input wire logic i_attention_message_fatal,
  // status toward host
  output logic o_subsystem_ready_flag,
  output logic o_msg_done,
  output logic o_msg_attention_message
);
  import tsmp_pkg::*;

  // writer, buffer and ownership state
  tsmp_state_t state;
  tsmp_word_t msg_buf [0:7];
  tsmp_word_t pkt [0:7];
  logic [2:0] wr_idx;
  logic [2:0] last_idx;
  logic ext_en;
  logic attention_message_en;
  logic owned;
  logic pend;
  logic pend_fatal;
  logic is_attention_message;

  // apb decode
  logic acc;
  logic wr_ctrl;
  logic is_ctrl;
  logic is_stat;
  logic is_buf;

  // message source selection
  logic start_cmd;
  logic start_attention_message;
  logic start;
  logic src_ack;
  logic [2:0] src_tclass;
  logic [3:0] src_class;
  tsmp_word_t hdr_word;
  tsmp_word_t resid_word;
  tsmp_word_t xs [0:4];
  tsmp_word_t next_pkt [0:7];
  logic [2:0] next_last;
  logic [31:0] next_rdata;

  assign acc = i_psel & i_penable & ~o_pready;
  assign is_ctrl = (i_paddr == `TSMP_A_CTRL);
  assign is_stat = (i_paddr == `TSMP_A_STAT);
  assign is_buf = ((i_paddr & `TSMP_A_BUF_MASK) == `TSMP_A_BUF);
  // a write lands only at the edge that samples pready high
  assign wr_ctrl = i_psel & i_penable & o_pready & i_pwrite & is_ctrl;

  // a command answer wins over a pending attention
  assign start_cmd = (state == tsmp_idle) & i_cmd_done;
  assign start_attention_message = (state == tsmp_idle) & ~i_cmd_done & pend & owned & attention_message_en;
  assign start = start_cmd | start_attention_message;

  // extended status words as an indexed set
  assign xs[0] = i_ext_status_0;
  assign xs[1] = i_ext_status_1;
  assign xs[2] = i_ext_status_2;
  assign xs[3] = i_ext_status_3;
  assign xs[4] = i_ext_status_4;

  // header source per message kind
  always_comb begin
    if (start_cmd) begin
      src_ack = 1'b1;
      src_tclass = i_tclass;
      src_class = i_class_code;
    end else if (pend_fatal) begin
      src_ack = 1'b0;
      src_tclass = `TSMP_TC_FATAL;
      src_class = `TSMP_CC_DIAG;
    end else begin
      src_ack = 1'b0;
      src_tclass = `TSMP_TC_LINE;
      src_class = `TSMP_CC_LINE;
    end
  end

  tsmp_hdr_build u_hdr (
    .i_ack(src_ack),
    .i_tclass(src_tclass),
    .i_class_code(src_class),
    .o_header(hdr_word)
  );

  tsmp_resid_calc u_resid (
    .i_cmd(start_cmd ? i_cmd_kind : tsmp_cmd_other),
    .i_req(i_req_count),
    .i_act(i_act_count),
    .o_resid(resid_word)
  );

  // packet image taken at message start
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      next_pkt[k] = 16'h0000;
    end
    next_pkt[`TSMP_W_HDR] = hdr_word;
    next_pkt[`TSMP_W_LEN] = {`TSMP_LEN_PAD, ext_en ? `TSMP_LEN_EXT : `TSMP_LEN_STD};
    next_pkt[`TSMP_W_RES] = resid_word;
    for (int k = 0; k < 5; k++) begin
      next_pkt[3'(k) + `TSMP_W_XS0] = xs[k];
    end
    next_last = ext_en ? `TSMP_N_EXT : `TSMP_N_STD;
  end

  // snapshot of packet words
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int k = 0; k < 8; k++) begin
        pkt[k] <= 16'h0000;
      end
      last_idx <= `TSMP_N_STD;
      is_attention_message <= 1'b0;
    end else if (start) begin
      for (int k = 0; k < 8; k++) begin
        pkt[k] <= next_pkt[k];
      end
      last_idx <= next_last;
      is_attention_message <= start_attention_message;
    end
  end

  // writer sequence
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= tsmp_idle;
      wr_idx <= 3'h0;
    end else begin
      case (state)
        tsmp_idle: begin
          wr_idx <= 3'h0;
          if (start) begin
            state <= tsmp_write;
          end
        end
        tsmp_write: begin
          wr_idx <= 3'(wr_idx + 3'h1);
          if (wr_idx == last_idx) begin
            state <= tsmp_finish;
          end
        end
        tsmp_finish: begin
          state <= tsmp_idle;
        end
        default: begin
          state <= tsmp_idle;
        end
      endcase
    end
  end

  // message buffer, one word per cycle ascending
  for (genvar g = 0; g < `TSMP_N_WORDS; g++) begin
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        msg_buf[g] <= 16'h0000;
      end else if ((state == tsmp_write) && (wr_idx == 3'(g))) begin
        msg_buf[g] <= pkt[g];
      end
    end
  end

  // completion pulses toward the host
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_msg_done <= 1'b0;
      o_msg_attention_message <= 1'b0;
    end else begin
      o_msg_done <= (state == tsmp_finish);
      o_msg_attention_message <= (state == tsmp_finish) & is_attention_message;
    end
  end

  // ready flag, low from start until one cycle after the last word is in, rising with done
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_subsystem_ready_flag <= 1'b1;
    end else if (start) begin
      o_subsystem_ready_flag <= 1'b0;
    end else if (state == tsmp_finish) begin
      o_subsystem_ready_flag <= 1'b1;
    end
  end

  // attention queue, a new condition beats the clear
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend <= 1'b0;
      pend_fatal <= 1'b0;
    end else begin
      pend <= i_attention_message_line | i_attention_message_fatal | (pend & ~start_attention_message);
      pend_fatal <= i_attention_message_fatal | (pend_fatal & ~start_attention_message);
    end
  end

  // buffer ownership, control bits
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      owned <= 1'b0;
      ext_en <= 1'b0;
      attention_message_en <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ext_en <= i_pwdata[`TSMP_C_EXT];
        attention_message_en <= i_pwdata[`TSMP_C_AEN];
      end
      if (wr_ctrl & i_pwdata[`TSMP_C_REL]) begin
        owned <= 1'b1;
      end else if (start_attention_message) begin
        owned <= 1'b0;
      end
    end
  end

  // apb handshake, one wait cycle
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= acc;
      o_pslverr <= acc & ~(is_ctrl | is_stat | is_buf);
    end
  end

  // read data select, zero for writes and holes
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (acc & ~i_pwrite) begin
      if (is_ctrl) begin
        next_rdata[`TSMP_C_EXT] = ext_en;
        next_rdata[`TSMP_C_AEN] = attention_message_en;
      end else if (is_stat) begin
        next_rdata[`TSMP_S_RDY] = o_subsystem_ready_flag;
        next_rdata[`TSMP_S_BUSY] = (state != tsmp_idle);
        next_rdata[`TSMP_S_OWN] = owned;
        next_rdata[`TSMP_S_PEND] = pend;
        next_rdata[`TSMP_S_EXT] = ext_en;
      end else if (is_buf) begin
        next_rdata[`TSMP_D_HI:`TSMP_D_LO] = msg_buf[i_paddr[`TSMP_A_IDX_HI:`TSMP_A_IDX_LO]];
      end
    end
  end

  // read data register, stands with pready
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata <= 32'h0000_0000;
    end else begin
      o_prdata <= next_rdata;
    end
  end
endmodule

// file: rtl/tsmp_defs.svh
// Purpose: offsets, field positions and codes of the status message packer
// Assumes: 32-bit apb data, 16-bit packet words
// Notes: definitions only
`ifndef TSMP_DEFS_SVH
`define TSMP_DEFS_SVH

// header word fields
`define TSMP_ACK_BIT 15
`define TSMP_RSV_HI 14
`define TSMP_RSV_LO 12
`define TSMP_RSV_ZERO 3'h0
`define TSMP_CLS_HI 11
`define TSMP_CLS_LO 8
`define TSMP_FMT_HI 7
`define TSMP_FMT_LO 5
`define TSMP_FMT_ONE 3'h0
`define TSMP_TYP_HI 4
`define TSMP_TYP_LO 0

// message types
`define TSMP_T_END 5'h10
`define TSMP_T_FAIL 5'h11
`define TSMP_T_ERR 5'h12
`define TSMP_T_ATTENTION_MESSAGE 5'h13

// termination classes with a fixed meaning
`define TSMP_TC_NORM 3'h0
`define TSMP_TC_LINE 3'h1
`define TSMP_TC_ALERT 3'h2
`define TSMP_TC_REJ 3'h3
`define TSMP_TC_FATAL 3'h7

// class codes
`define TSMP_CC_NONE 4'h0
`define TSMP_CC_LINE 4'h0
`define TSMP_CC_ILL 4'h1
`define TSMP_CC_WLOCK 4'h2
`define TSMP_CC_DIAG 4'h3

// length word
`define TSMP_LEN_PAD 8'h00
`define TSMP_LEN_STD 8'h0a
`define TSMP_LEN_EXT 8'h0c

// packet word positions and sizes
`define TSMP_W_HDR 3'h0
`define TSMP_W_LEN 3'h1
`define TSMP_W_RES 3'h2
`define TSMP_W_XS0 3'h3
`define TSMP_N_STD 3'h6
`define TSMP_N_EXT 3'h7
`define TSMP_N_WORDS 8

// apb map
`define TSMP_A_CTRL 8'h00
`define TSMP_A_STAT 8'h04
`define TSMP_A_BUF 8'h20
`define TSMP_A_BUF_MASK 8'he0
`define TSMP_A_IDX_HI 4
`define TSMP_A_IDX_LO 2
`define TSMP_D_HI 15
`define TSMP_D_LO 0
`define TSMP_C_EXT 0
`define TSMP_C_AEN 1
`define TSMP_C_REL 2
`define TSMP_S_RDY 0
`define TSMP_S_BUSY 1
`define TSMP_S_OWN 2
`define TSMP_S_PEND 3
`define TSMP_S_EXT 4

`endif

// file: rtl/tsmp_pkg.sv
// Purpose: types shared by the status message packer
// Assumes: nothing
// Notes: enums carry no explicit codes
package tsmp_pkg;
  typedef enum logic [1:0] {
    tsmp_cmd_other,
    tsmp_cmd_read,
    tsmp_cmd_space,
    tsmp_cmd_skip
  } tsmp_cmd_t;
  typedef enum logic [1:0] {
    tsmp_idle,
    tsmp_write,
    tsmp_finish
  } tsmp_state_t;
  typedef logic [15:0] tsmp_word_t;
endpackage

// file: rtl/tsmp_hdr_build.sv
// Purpose: forms the header word of a status message
// Assumes: termination class and class code are stable while read
// Notes: purely combinational
`timescale 1ns/1ps
`include "tsmp_defs.svh"
module tsmp_hdr_build (
  // message source
  input wire logic i_ack,
  input wire logic [2:0] i_tclass,
  input wire logic [3:0] i_class_code,
  // header word
  output tsmp_pkg::tsmp_word_t o_header
);
  import tsmp_pkg::*;
  logic [4:0] msg_type;
  logic [3:0] cls;

  // termination class to message type
  always_comb begin
    case (i_tclass)
      `TSMP_TC_NORM, `TSMP_TC_ALERT: msg_type = `TSMP_T_END;
      `TSMP_TC_REJ: msg_type = `TSMP_T_FAIL;
      `TSMP_TC_LINE, `TSMP_TC_FATAL: msg_type = `TSMP_T_ATTENTION_MESSAGE;
      default: msg_type = `TSMP_T_ERR;
    endcase
  end

  // class code only outside a normal end
  always_comb begin
    if (msg_type == `TSMP_T_END) begin
      cls = `TSMP_CC_NONE;
    end else begin
      cls = i_class_code;
    end
  end

  // field assembly
  always_comb begin
    o_header = '0;
    o_header[`TSMP_ACK_BIT] = i_ack;
    o_header[`TSMP_RSV_HI:`TSMP_RSV_LO] = `TSMP_RSV_ZERO;
    o_header[`TSMP_CLS_HI:`TSMP_CLS_LO] = cls;
    o_header[`TSMP_FMT_HI:`TSMP_FMT_LO] = `TSMP_FMT_ONE;
    o_header[`TSMP_TYP_HI:`TSMP_TYP_LO] = msg_type;
  end
endmodule

// file: rtl/tsmp_resid_calc.sv
// Purpose: residual count word of a status message
// Assumes: actual count never exceeds requested count
// Notes: zero for commands without a count
`timescale 1ns/1ps
`include "tsmp_defs.svh"
module tsmp_resid_calc (
  // command outcome
  input wire tsmp_pkg::tsmp_cmd_t i_cmd,
  input wire tsmp_pkg::tsmp_word_t i_req,
  input wire tsmp_pkg::tsmp_word_t i_act,
  // residual
  output tsmp_pkg::tsmp_word_t o_resid
);
  import tsmp_pkg::*;

  // requested minus done, also on early stop
  always_comb begin
    case (i_cmd)
      tsmp_cmd_read: o_resid = 16'(i_req - i_act);
      tsmp_cmd_space: o_resid = 16'(i_req - i_act);
      tsmp_cmd_skip: o_resid = 16'(i_req - i_act);
      default: o_resid = 16'h0000;
    endcase
  end
endmodule

// file: tb/tsmp_packer_properties.sv
// Purpose: port checks of the packer
// Assumes: one clock domain
// Notes: bound below
`timescale 1ns/1ps
module tsmp_packer_chk (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // message
  input wire logic i_cmd_done,
  input wire logic o_subsystem_ready_flag,
  input wire logic o_msg_done,
  input wire logic o_msg_attention_message
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic seen, by_cmd, ack;
  wire rdy = o_subsystem_ready_flag;
  wire rd_hdr = o_pready && !i_pwrite && seen && i_paddr == 8'h20;
  wire rd_len = o_pready && !i_pwrite && seen && i_paddr == 8'h24;
  // tracks whether the last message answered a command
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen <= 1'b0;
      by_cmd <= 1'b0;
      ack <= 1'b0;
    end else if (o_msg_done) begin
      seen <= 1'b1;
      by_cmd <= i_cmd_done;
      ack <= by_cmd;
    end else if (i_cmd_done && rdy) begin
      by_cmd <= 1'b1;
    end
  end
  sequence s_busy;
    (!rdy)[*8];
  endsequence
  sequence s_end;
    o_msg_done && rdy;
  endsequence
  chk_apb_answer: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("apb answer late");
  chk_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready not a pulse");
  chk_err_pready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  chk_cmd_take: assert property (i_cmd_done && rdy && !o_msg_done |=> !rdy)
    else $error("ready not cleared at start");
  chk_msg_span: assert property ($fell(rdy) |-> s_busy ##[1:2] s_end)
    else $error("message span wrong");
  chk_done_ready: assert property (o_msg_done |-> rdy && !$past(rdy))
    else $error("done without ready rise");
  chk_done_pulse: assert property (o_msg_done |=> !o_msg_done)
    else $error("done not a pulse");
  chk_attention_message_done: assert property (o_msg_attention_message |-> o_msg_done)
    else $error("attention flag alone");
  chk_hdr_fixed: assert property (rd_hdr |-> o_prdata[14:12] == 3'h0 && o_prdata[7:3] == 5'h02)
    else $error("header fixed fields wrong");
  chk_hdr_ack: assert property (rd_hdr |-> o_prdata[15] == ack)
    else $error("header ack wrong");
  chk_len_word: assert property (rd_len |-> o_prdata[15:8] == 8'h00 && o_prdata[7:0] inside {8'h0a, 8'h0c})
    else $error("length word wrong");
endmodule
bind tsmp_packer tsmp_packer_chk u_chk (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_cmd_done(i_cmd_done), .o_subsystem_ready_flag(o_subsystem_ready_flag),
  .o_msg_done(o_msg_done), .o_msg_attention_message(o_msg_attention_message));

// file: tb/tsmp_host_bfm.sv
// Purpose: host reading the message buffer over apb
// Assumes: slave answers with pready
// Notes: released write data is inverted
`timescale 1ns/1ps
module tsmp_host_bfm (
  // clock
  input wire logic i_core_clk,
  // apb master
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr
);
  // idle bus at time zero
  initial begin
    {o_psel, o_penable, o_pwrite} = 3'h0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // one transfer held until pready at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge i_core_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_core_clk);
    o_penable <= 1'b1;
    do @(posedge i_core_clk); while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_pwdata <= ~d;
  endtask
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench of the packer
// Assumes: host model drives apb
// Notes: buffer read back after each message
`timescale 1ns/1ps
module tb_top;
  import tsmp_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_arst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, i_cmd_done;
  logic i_attention_message_line, i_attention_message_fatal, o_subsystem_ready_flag, o_msg_done, o_msg_attention_message;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, q;
  tsmp_cmd_t i_cmd_kind;
  logic [2:0] i_tclass;
  logic [3:0] i_class_code;
  tsmp_word_t i_req_count, i_act_count, i_ext_status_0, i_ext_status_1;
  tsmp_word_t i_ext_status_2, i_ext_status_3, i_ext_status_4;
  tsmp_word_t w [8];
  logic [4:0] tyt [8] = '{5'h10, 5'h13, 5'h10, 5'h11, 5'h12, 5'h12, 5'h12, 5'h13};
  logic e, ext;
  int mismatches, samples_checked;
  // clock
  always #2 i_core_clk = ~i_core_clk;
  tsmp_packer u_dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_cmd_done(i_cmd_done), .i_cmd_kind(i_cmd_kind), .i_tclass(i_tclass),
    .i_class_code(i_class_code), .i_req_count(i_req_count), .i_act_count(i_act_count),
    .i_ext_status_0(i_ext_status_0), .i_ext_status_1(i_ext_status_1), .i_ext_status_2(i_ext_status_2),
    .i_ext_status_3(i_ext_status_3), .i_ext_status_4(i_ext_status_4), .i_attention_message_line(i_attention_message_line),
    .i_attention_message_fatal(i_attention_message_fatal), .o_subsystem_ready_flag(o_subsystem_ready_flag), .o_msg_done(o_msg_done),
    .o_msg_attention_message(o_msg_attention_message));
  tsmp_host_bfm u_host (.i_core_clk(i_core_clk), .o_psel(i_psel), .o_penable(i_penable),
    .o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata), .i_prdata(o_prdata),
    .i_pready(o_pready), .i_pslverr(o_pslverr));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  // pulses a source and waits for the completion pulse
  task automatic msg(input logic c, input logic l, input logic f);
    int n;
    @(posedge i_core_clk);
    {i_cmd_done, i_attention_message_line, i_attention_message_fatal} <= {c, l, f};
    @(posedge i_core_clk);
    {i_cmd_done, i_attention_message_line, i_attention_message_fatal} <= 3'h0;
    @(negedge i_core_clk);
    if (c) chk(o_subsystem_ready_flag, 1'b0);
    for (n = 0; n < 40 && o_msg_done !== 1'b1; n++) @(negedge i_core_clk);
    if (c) chk(n, ext ? 9 : 8);
    chk(o_msg_done, 1'b1);
    if (!c) chk(o_msg_attention_message, 1'b1);
  endtask
  // reset state, registers and an unmapped read
  task automatic t_basic;
    @(negedge i_core_clk);
    chk(o_subsystem_ready_flag, 1'b1);
    rd(8'h04);
    chk(q, 32'h1);
    rd(8'h00);
    chk(q, 32'h0);
    rd(8'h10);
    chk(q, 32'h0);
    chk(e, 1'b1);
    $display("test basic done");
  endtask
  // one command answer per termination class
  task automatic cmd_case(input int t);
    logic [3:0] cc;
    cc = 4'(t + 1);
    @(posedge i_core_clk);
    i_cmd_kind <= tsmp_cmd_t'(t % 4);
    i_tclass <= 3'(t);
    i_class_code <= cc;
    i_req_count <= 16'h0200 + 16'(t);
    i_act_count <= 16'h0080;
    {i_ext_status_0, i_ext_status_1} <= {16'(t * 5 + 1), 16'(t * 5 + 2)};
    {i_ext_status_2, i_ext_status_3, i_ext_status_4} <= {16'(t * 5 + 3), 16'(t * 5 + 4), 16'(t * 5 + 5)};
    w[0] = {4'h8, tyt[t] == 5'h10 ? 4'h0 : cc, 3'h0, tyt[t]};
    w[1] = {8'h00, ext ? 8'h0c : 8'h0a};
    w[2] = (t % 4 == 0) ? 16'h0 : 16'h0180 + 16'(t);
    for (int j = 0; j < 5; j++) w[3 + j] = 16'(t * 5 + j + 1);
    msg(1'b1, 1'b0, 1'b0);
    for (int i = 0; i <= (ext ? 7 : 6); i++) begin
      rd(8'h20 + 8'(4 * i));
      chk(q, {16'h0, w[i]});
    end
  endtask
  // attention emitted, then queued until release
  task automatic t_attention_message;
    ext = 1'b0;
    wr(8'h00, 32'h6);
    msg(1'b0, 1'b1, 1'b0);
    rd(8'h20);
    chk(q, 32'h0013);
    @(posedge i_core_clk);
    i_attention_message_fatal <= 1'b1;
    @(posedge i_core_clk);
    i_attention_message_fatal <= 1'b0;
    repeat (20) begin
      @(negedge i_core_clk);
      chk(o_msg_done, 1'b0);
    end
    rd(8'h04);
    chk(q, 32'h9);
    rd(8'h00);
    chk(q, 32'h2);
    wr(8'h00, 32'h6);
    msg(1'b0, 1'b0, 1'b0);
    rd(8'h20);
    chk(q, 32'h0313);
    $display("test attention done");
  endtask
  // main sequence
  initial begin
    {i_arst_n, i_cmd_done, i_attention_message_line, i_attention_message_fatal, ext} = 5'h0;
    i_cmd_kind = tsmp_cmd_other;
    {i_tclass, i_class_code, i_req_count, i_act_count} = '0;
    {i_ext_status_0, i_ext_status_1, i_ext_status_2, i_ext_status_3, i_ext_status_4} = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (8) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    t_basic;
    for (int x = 0; x < 2; x++) begin
      ext = x[0];
      wr(8'h00, {31'h0, ext});
      for (int t = 0; t < 8; t++) cmd_case(t);
      $display("test commands ext %0d done", x);
    end
    t_attention_message;
    results;
  end
  // watchdog
  initial begin
    repeat (8000) @(posedge i_core_clk);
    mismatches++;
    results;
  end
endmodule
